// ---- include/rectifier_pkg.sv ----
`default_nettype none
package rectifier_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLOCK_HZ        = 100_000_000;
	localparam int unsigned ENABLE_DELAY_MS = 50;
	localparam int unsigned GOOD_DELAY_MS   = 50;
	localparam int unsigned ENABLE_DELAY_CYCLES = ENABLE_DELAY_MS * (CLOCK_HZ / 1000);
	localparam int unsigned GOOD_DELAY_CYCLES   = GOOD_DELAY_MS * (CLOCK_HZ / 1000);

	// ----------------------------------------
	// bus thresholds in volts
	// ----------------------------------------
	localparam logic [9:0] DOUBLER_LIMIT_V  = 10'd200;
	localparam logic [9:0] BYPASS_LIMIT_V   = 10'd235;
	localparam logic [9:0] GOOD_DROP_V      = 10'd210;
	localparam logic [9:0] DISABLE_V        = 10'd190;
	localparam logic [9:0] OVERVOLT_V       = 10'd400;
	localparam logic [9:0] FAULT_V          = 10'd180;

	// ----------------------------------------
	// slope detector defaults
	// ----------------------------------------
	localparam int unsigned SLOPE_INTERVAL_CYCLES = 100_000;
	localparam logic [9:0]  SLOPE_STEP_V          = 10'd2;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_CHARGE,
		ST_DOUBLED,
		ST_WAIT_ENABLE,
		ST_WAIT_GOOD,
		ST_RUN,
		ST_FAULT
	} seq_state_t;

	typedef struct packed {
		logic doubler_on;
		logic bypass_closed;
		logic converter_enable;
		logic bus_good_flag_n;
	} drive_t;

	localparam drive_t SAFE_DRIVE = 4'b0001;

endpackage : rectifier_pkg
`default_nettype wire

// ---- logic/slope_detect.sv ----
`timescale 1ns/1ps
`default_nettype none
module slope_detect #(
	parameter int unsigned INTERVAL = rectifier_pkg::SLOPE_INTERVAL_CYCLES,
	parameter logic [9:0]  STEP     = rectifier_pkg::SLOPE_STEP_V
) (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       sync_clear,
	input  wire logic [9:0] bus_volts,
	output logic            flat
);
	logic [31:0] tick;
	logic [31:0] next_tick;
	logic [9:0]  last;
	logic [9:0]  next_last;
	logic        next_flat;

	function automatic logic [9:0] abs_diff(input logic [9:0] a, input logic [9:0] b);
		abs_diff = (a > b) ? (a - b) : (b - a);
	endfunction : abs_diff

	// sample bus each interval, flag small change
	always_comb begin
		next_tick = tick + 32'h1;
		next_last = last;
		next_flat = flat;
		if (sync_clear) begin
			next_tick = 32'h0;
			next_last = 10'h0;
			next_flat = 1'b0;
		end else if (tick >= INTERVAL - 1) begin
			next_tick = 32'h0;
			next_last = bus_volts;
			next_flat = abs_diff(bus_volts, last) < STEP;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tick <= 32'h0;
			last <= 10'h0;
			flat <= 1'b0;
		end else begin
			tick <= next_tick;
			last <= next_last;
			flat <= next_flat;
		end
	end
endmodule : slope_detect
`default_nettype wire

// ---- logic/rectifier_bus_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
module rectifier_bus_sequencer #(
	parameter int unsigned ENABLE_DELAY   = rectifier_pkg::ENABLE_DELAY_CYCLES,
	parameter int unsigned GOOD_DELAY     = rectifier_pkg::GOOD_DELAY_CYCLES,
	parameter int unsigned SLOPE_INTERVAL = rectifier_pkg::SLOPE_INTERVAL_CYCLES,
	parameter logic [9:0]  SLOPE_STEP     = rectifier_pkg::SLOPE_STEP_V
) (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       sync_reset,
	input  wire logic [9:0] bus_volts,
	output logic            doubler_on,
	output logic            bypass_closed,
	output logic            converter_enable,
	output logic            bus_good_flag_n
);
	// ----------------------------------------
	// input synchroniser
	// ----------------------------------------
	logic [9:0] volts_meta;
	logic [9:0] volts;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			volts_meta <= 10'h0;
			volts      <= 10'h0;
		end else begin
			volts_meta <= bus_volts;
			volts      <= volts_meta;
		end
	end

	// ----------------------------------------
	// slope detector
	// ----------------------------------------
	logic flat;
	logic slope_restart; // fresh measurement on every new power-up

	slope_detect #(
		.INTERVAL (SLOPE_INTERVAL),
		.STEP     (SLOPE_STEP)
	) u_slope (
		.clock      (clock),
		.rst_n      (rst_n),
		.sync_clear (slope_restart),
		.bus_volts  (volts),
		.flat       (flat)
	);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	rectifier_pkg::seq_state_t state;
	rectifier_pkg::seq_state_t next_state;
	rectifier_pkg::drive_t     drive;
	rectifier_pkg::drive_t     next_drive;
	logic [31:0]               count;
	logic [31:0]               next_count;
	logic                      over_v;
	logic                      under_disable;
	logic                      under_fault;
	logic                      armed;

	// ----------------------------------------
	// threshold decode
	// ----------------------------------------
	// settled bus low enough to need the doubler
	function automatic logic doubler_ready(input logic settled, input logic [9:0] level);
		doubler_ready = settled && (level < rectifier_pkg::DOUBLER_LIMIT_V);
	endfunction : doubler_ready

	// settled bus high enough to short the inrush resistor
	function automatic logic bypass_ready(input logic settled, input logic [9:0] level);
		bypass_ready = settled && (level > rectifier_pkg::BYPASS_LIMIT_V);
	endfunction : bypass_ready

	// ----------------------------------------
	// protection decode
	// ----------------------------------------
	// protection only once the bypass may have closed
	function automatic logic protection_armed(input rectifier_pkg::seq_state_t st);
		protection_armed = (st != rectifier_pkg::ST_CHARGE) && (st != rectifier_pkg::ST_DOUBLED);
	endfunction : protection_armed

	// bus level comparisons for protection
	assign over_v        = volts > rectifier_pkg::OVERVOLT_V;
	assign under_disable = volts < rectifier_pkg::DISABLE_V;
	assign under_fault   = volts < rectifier_pkg::FAULT_V;
	assign armed         = protection_armed(state);

	// next state, outputs and delay counter
	always_comb begin
		next_state = state;
		next_drive = drive;
		next_count = count;
		slope_restart = 1'b0;
		case (state)
			rectifier_pkg::ST_CHARGE: begin
				next_count = 32'h0;
				if (doubler_ready(flat, volts)) begin
					next_drive.doubler_on = 1'b1;
					next_state = rectifier_pkg::ST_DOUBLED;
				end else if (bypass_ready(flat, volts)) begin
					next_drive.bypass_closed = 1'b1;
					next_state = rectifier_pkg::ST_WAIT_ENABLE;
				end
			end
			rectifier_pkg::ST_DOUBLED: begin
				// doubler stays engaged while bus climbs again
				if (bypass_ready(flat, volts)) begin
					next_drive.bypass_closed = 1'b1;
					next_state = rectifier_pkg::ST_WAIT_ENABLE;
				end
			end
			rectifier_pkg::ST_WAIT_ENABLE: begin
				next_count = count + 32'h1;
				if (count >= ENABLE_DELAY - 1) begin
					next_count = 32'h0;
					next_drive.converter_enable = 1'b1;
					next_state = rectifier_pkg::ST_WAIT_GOOD;
				end
			end
			rectifier_pkg::ST_WAIT_GOOD: begin
				next_count = count + 32'h1;
				if (count >= GOOD_DELAY - 1) begin
					next_count = 32'h0;
					next_state = rectifier_pkg::ST_RUN;
					// a bus already sagging below the drop level is not reported good
					if (volts >= rectifier_pkg::GOOD_DROP_V)
						next_drive.bus_good_flag_n = 1'b0;
				end
			end
			rectifier_pkg::ST_RUN: begin
				// bus good follows hysteresis while running, ride-through kept
				if (volts < rectifier_pkg::GOOD_DROP_V)
					next_drive.bus_good_flag_n = 1'b1;
				else if (volts > rectifier_pkg::BYPASS_LIMIT_V)
					next_drive.bus_good_flag_n = 1'b0;
			end
			rectifier_pkg::ST_FAULT: begin
				// wait for bus to collapse, then run full power-up
				next_count = 32'h0;
				if (under_disable)
					next_state = rectifier_pkg::ST_CHARGE;
			end
			default: begin
				next_state = rectifier_pkg::ST_CHARGE;
				next_drive = rectifier_pkg::SAFE_DRIVE;
			end
		endcase
		// protection overrides sequencing
		if (armed) begin
			if (over_v) begin
				next_drive.converter_enable = 1'b0;
				next_drive.bypass_closed    = 1'b0;
				next_drive.bus_good_flag_n  = 1'b1;
				next_count = 32'h0;
				next_state = rectifier_pkg::ST_FAULT;
			end else if (under_disable) begin
				next_drive = rectifier_pkg::SAFE_DRIVE;
				next_count = 32'h0;
				next_state = rectifier_pkg::ST_CHARGE;
				slope_restart = 1'b1;
			end
		end
		// a collapsing bus always drops the bypass, whatever the state
		if (under_fault)
			next_drive.bypass_closed = 1'b0;
		// synchronous reset wins over everything
		if (sync_reset) begin
			next_state = rectifier_pkg::ST_CHARGE;
			next_drive = rectifier_pkg::SAFE_DRIVE;
			next_count = 32'h0;
			slope_restart = 1'b1;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	// register sequencer state, safe at power-on
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= rectifier_pkg::ST_CHARGE;
			drive <= rectifier_pkg::SAFE_DRIVE;
			count <= 32'h0;
		end else begin
			state <= next_state;
			drive <= next_drive;
			count <= next_count;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// outputs straight from registers
	assign doubler_on       = drive.doubler_on;
	assign bypass_closed    = drive.bypass_closed;
	assign converter_enable = drive.converter_enable;
	assign bus_good_flag_n  = drive.bus_good_flag_n;
endmodule : rectifier_bus_sequencer
`default_nettype wire

// ---- bench/rectifier_bus_sequencer_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module rectifier_bus_sequencer_checker #(
	parameter int unsigned ENABLE_DELAY = 20,
	parameter int unsigned GOOD_DELAY   = 20
) (
	input wire logic       clock,
	input wire logic       rst_n,
	input wire logic       sync_reset,
	input wire logic [9:0] bus_volts,
	input wire logic       doubler_on,
	input wire logic       bypass_closed,
	input wire logic       converter_enable,
	input wire logic       bus_good_flag_n
);
	// ----------------------------------------
	// sequencing checks
	// ----------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	chk_enable_delay: assert property ($rose(converter_enable) |->
		$past(bypass_closed, ENABLE_DELAY) && !$past(bypass_closed, ENABLE_DELAY + 1)) else $error("enable delay");
	chk_good_delay: assert property ($fell(bus_good_flag_n) |->
		converter_enable && $past(converter_enable, GOOD_DELAY)) else $error("good delay");
	chk_enable_bypass: assert property (converter_enable |-> bypass_closed) else $error("enable early");
	chk_good_enable: assert property (!bus_good_flag_n |-> converter_enable) else $error("good order");
	chk_over_volt: assert property ((bus_volts > 10'd400)[*5] |-> !converter_enable) else $error("overvolt");
	chk_drop_both: assert property ($fell(converter_enable) |-> $fell(bypass_closed)) else $error("drop");
	chk_good_drop: assert property ((bus_volts < 10'd210)[*4] |-> bus_good_flag_n) else $error("good drop");
	chk_low_bus: assert property ((bus_volts < 10'd190)[*4] |->
		!converter_enable && !bypass_closed) else $error("low bus");
	chk_restart_idle: assert property ($fell(converter_enable) && (bus_volts < 10'd190) |->
		!doubler_on) else $error("restart doubler");
	chk_sync_clear: assert property (sync_reset |-> ##2
		bus_good_flag_n && !converter_enable && !bypass_closed && !doubler_on) else $error("sync reset");
endmodule : rectifier_bus_sequencer_checker
bind rectifier_bus_sequencer rectifier_bus_sequencer_checker #(
	.ENABLE_DELAY(ENABLE_DELAY), .GOOD_DELAY(GOOD_DELAY)) u_chk (.clock(clock), .rst_n(rst_n),
	.sync_reset(sync_reset), .bus_volts(bus_volts), .doubler_on(doubler_on), .bypass_closed(bypass_closed),
	.converter_enable(converter_enable), .bus_good_flag_n(bus_good_flag_n));
`default_nettype wire

// ---- bench/converter_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module converter_model (
	input  wire logic clock,
	input  wire logic converter_enable,
	input  wire logic bus_good_flag_n,
	output var logic  converter_on,
	output var logic  shutdown_req
);
	// converters follow enable, monitor warns on lost bus good
	always_ff @(posedge clock) begin
		converter_on <= converter_enable;
		shutdown_req <= converter_on && bus_good_flag_n;
	end
endmodule : converter_model
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
	$display("unexpected at %0t: %h %h", $time, (a), (b)); end end
module tb_top;
	logic                  clock      = 1'b0;
	logic                  rst_n      = 1'b0;
	logic                  sync_reset = 1'b0;
	logic [9:0]            bus_volts  = 10'd220;
	logic                  doubler_on, bypass_closed, converter_enable, bus_good_flag_n;
	logic                  converter_on, shutdown_req;
	rectifier_pkg::drive_t o;
	int                    num_errors  = 0;
	int                    check_count = 0;
	int                    n;
	assign o = {doubler_on, bypass_closed, converter_enable, bus_good_flag_n};
	always #5 clock = ~clock;
	rectifier_bus_sequencer #(.ENABLE_DELAY(20), .GOOD_DELAY(20), .SLOPE_INTERVAL(8)) dut (.clock(clock),
		.rst_n(rst_n), .sync_reset(sync_reset), .bus_volts(bus_volts), .doubler_on(doubler_on),
		.bypass_closed(bypass_closed), .converter_enable(converter_enable), .bus_good_flag_n(bus_good_flag_n));
	converter_model partner (.clock(clock), .converter_enable(converter_enable),
		.bus_good_flag_n(bus_good_flag_n), .converter_on(converter_on), .shutdown_req(shutdown_req));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task print_verdict;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict
	// drive bus level, then wait c cycles
	task hold(input logic [9:0] v, input int c);
		@(posedge clock);
		bus_volts <= v;
		repeat (c) @(negedge clock);
	endtask : hold
	// bounded wait for an output pattern
	task wait_for(input rectifier_pkg::drive_t w);
		n = 0;
		while (o !== w && n < 500) begin
			@(negedge clock);
			n++;
		end
	endtask : wait_for
	task power_up(input logic d);
		wait_for({d, 3'b101});
		`CHK(o, {d, 3'b101})
		wait_for({d, 3'b111});
		`CHK(n, 20)
		wait_for({d, 3'b110});
		`CHK(n, 20)
		`CHK(converter_on, 1'b1)
	endtask : power_up
	task test_safe;
		`CHK(o, rectifier_pkg::SAFE_DRIVE)
		hold(10'd220, 60);
		`CHK(o, rectifier_pkg::SAFE_DRIVE)
	endtask : test_safe
	task test_doubler;
		hold(10'd150, 0);
		wait_for(4'b1001);
		`CHK(o, 4'b1001)
		hold(10'd300, 0);
		power_up(1'b1);
	endtask : test_doubler
	task test_ride;
		hold(10'd205, 6);
		`CHK(o, 4'b1111)
		`CHK(shutdown_req, 1'b1)
		hold(10'd300, 6);
		`CHK(o, 4'b1110)
	endtask : test_ride
	task test_restart;
		hold(10'd185, 6);
		`CHK(o, rectifier_pkg::SAFE_DRIVE)
		hold(10'd300, 0);
		power_up(1'b0);
	endtask : test_restart
	task test_overvolt;
		hold(10'd410, 6);
		`CHK(o, rectifier_pkg::SAFE_DRIVE)
		hold(10'd185, 6);
		hold(10'd300, 0);
		power_up(1'b0);
	endtask : test_overvolt
	task test_sync;
		@(posedge clock);
		sync_reset <= 1'b1;
		@(posedge clock);
		sync_reset <= 1'b0;
		repeat (2) @(negedge clock);
		`CHK(o, rectifier_pkg::SAFE_DRIVE)
	endtask : test_sync
	// main sequence and watchdog
	initial begin
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		@(negedge clock);
		test_safe();
		test_doubler();
		test_ride();
		test_restart();
		test_overvolt();
		test_sync();
		print_verdict();
	end
	initial begin
		#100000;
		num_errors++;
		print_verdict();
	end
endmodule : tb_top
`undef CHK
`default_nettype wire
